// [rtl/fpt_pkg.sv]
package fpt_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_DUTY_B = 6'h2B;
    localparam logic [5:0] IDX_GEN_CTRL = 6'h2C;
    localparam logic [5:0] IDX_PERIOD = 6'h2D;
    localparam logic [5:0] IDX_DUTY_A = 6'h2E;
    localparam logic [5:0] IDX_COUNTER = 6'h2F;
    localparam logic [5:0] IDX_TIMER_CTRL = 6'h30;
    localparam logic [5:0] IDX_PLL_CSR = 6'h27;
    localparam logic [5:0] IDX_FLAGS = 6'h38;
    localparam logic [5:0] IDX_MASK = 6'h39;
    localparam int ADDR_W = 8;

    // Field positions
    localparam int PLL_LOW_SPEED_BIT = 7;
    localparam int PLL_FAST_EN_BIT = 2;
    localparam int PLL_EN_BIT = 1;
    localparam int PLL_LOCK_BIT = 0;
    localparam int PWM_EN_BIT = 6;
    localparam int MODE_LSB = 4;
    localparam int LEGACY_BIT = 7;
    localparam int FLAG_CMP_A_BIT = 6;
    localparam int FLAG_CMP_B_BIT = 5;
    localparam int FLAG_OVF_BIT = 2;

    // Reset value, normal counter top and legacy fuse code
    localparam logic [7:0] PERIOD_RST = 8'hFF;
    localparam logic [7:0] COUNT_TOP_NORMAL = 8'hFF;
    localparam logic [3:0] FUSE_LEGACY = 4'h3;

    // Output mode codes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PAIR = 2'h1;
    localparam logic [1:0] MODE_CLR = 2'h2;
    localparam logic [1:0] MODE_SET = 2'h3;

    // Clock selection codes
    localparam logic [3:0] CS_STOP = 4'h0;
    localparam logic [3:0] CS_FAST_DIV8 = 4'h4;
    localparam logic [3:0] CS_SYS_DIV1 = 4'h5;

    // Timing
    localparam int CLK_MHZ = 40;
    localparam int FAST_MHZ_HIGH = 64;
    localparam int FAST_MHZ_LOW = 32;
    localparam int LOCK_TIME_US = 100;
    localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
    localparam int LOCK_CNT_W = 13;
endpackage

// [rtl/fpt_pwm_chan.sv]
`timescale 1ns/100ps
module fpt_pwm_chan #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wr_duty,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic pwm_en,
    input wire logic [1:0] out_mode,
    input wire logic [WIDTH-1:0] period,
    input wire logic [WIDTH-1:0] count,
    input wire logic step,
    output logic [WIDTH-1:0] duty_rd,
    output logic match,
    output logic out_true,
    output logic out_true_oe,
    output logic out_comp,
    output logic out_comp_oe
);
    import fpt_pkg::*;

    logic [WIDTH-1:0] buf_q, buf_d, act_q, act_d;
    logic match_q, match_d, lvl_q, lvl_d;
    logic to_q, to_d, co_q, co_d, toe_q, toe_d, coe_q, coe_d;
    logic set_lvl;

    always_comb begin
        buf_d = buf_q;
        act_d = act_q;
        lvl_d = lvl_q;
        match_d = 1'b0;
        set_lvl = (out_mode == MODE_SET);
        if (wr_duty) begin
            buf_d = wr_data; // (R13) (R14)
            if (!pwm_en) begin
                act_d = wr_data;
            end
        end
        if (step && pwm_en && count == period) begin
            act_d = buf_d; // (R13)
        end
        if (step) begin
            match_d = (count == act_q);
        end
        if (act_q == '0) begin
            lvl_d = set_lvl; // (R15)
        end else if (act_q == period) begin
            lvl_d = !set_lvl; // (R15)
        end else if (step && count == act_q) begin
            lvl_d = set_lvl; // (R11)
        end else if (step && count == WIDTH'(1)) begin
            lvl_d = !set_lvl; // (R11)
        end
        to_d = lvl_d;
        co_d = !lvl_d; // (R11) (R12)
        toe_d = pwm_en && out_mode != MODE_OFF;
        coe_d = pwm_en && out_mode == MODE_PAIR; // (R11)
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_q <= '0;
            act_q <= '0;
            lvl_q <= 1'b0;
            match_q <= 1'b0;
            to_q <= 1'b0;
            co_q <= 1'b0;
            toe_q <= 1'b0;
            coe_q <= 1'b0;
        end else begin
            buf_q <= buf_d;
            act_q <= act_d;
            lvl_q <= lvl_d;
            match_q <= match_d;
            to_q <= to_d;
            co_q <= co_d;
            toe_q <= toe_d;
            coe_q <= coe_d;
        end
    end

    assign duty_rd = buf_q;
    assign match = match_q;
    assign out_true = to_q;
    assign out_comp = co_q;
    assign out_true_oe = toe_q;
    assign out_comp_oe = coe_q;
endmodule

// [rtl/fpt_timer.sv]
// Contract
// (R1) Fast clock 64 MHz, 32 MHz when low-speed
// (R2) Software halts timer before changing low-speed
// (R3) PLL register bits 6..3 read zero
// (R4) Fast-clock enable selects fast or system clock
// (R5) Fast-clock enable sets only with PLL enabled
// (R6) PLL enable starts PLL; reads one if sysclk
// (R7) Lock indicator high only when locked, ~100us
// (R8) Software enables PLL, polls lock, then fast-clock
// (R9) Counter counts zero to period, then restarts; code does so only while a PWM channel is enabled, otherwise it counts to 0xFF
// (R10) At period counter clears, overflow flag set later
// (R11) Output mode code selects true/complement pin behaviour
// (R12) Two 8-bit glitch-free channels with complement outputs
// (R13) Duty writes buffered, loaded at period
// (R14) Duty reads return the buffered value
// (R15) Duty zero or period holds outputs static
// (R16) Interrupt needs flag, enable and global enable
// (R17) PWM frequency is timer clock over period+1
// (R18) Codes 0001..0100 give fast clock /1,/2,/4,/8
// (R19) Fuse code 0011 selects legacy-compatible mode
// (R20) Channel A enable gives PWM; clear after match
// (R21) Control synchronized in, flags synchronized back
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module fpt_timer #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [fpt_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic global_int_enable,
    input wire logic pll_is_sysclk,
    input wire logic [3:0] clock_config_fuses,
    output logic pll_run,
    output logic pwm_out_a,
    output logic pwm_out_a_oe,
    output logic pwm_out_a_n,
    output logic pwm_out_a_n_oe,
    output logic pwm_out_b,
    output logic pwm_out_b_oe,
    output logic pwm_out_b_n,
    output logic pwm_out_b_n_oe,
    output logic irq_overflow,
    output logic irq_cmp_a,
    output logic irq_cmp_b
);
    import fpt_pkg::*;

    function automatic logic [9:0] div_mask(input logic [3:0] e);
        div_mask = 10'((11'h001 << e) - 11'h001);
    endfunction

    // Bus and software-visible registers
    logic wait_q, wait_d;
    logic [31:0] rdata_q, rdata_d;
    logic low_speed_q, low_speed_d, fce_q, fce_d, pll_en_q, pll_en_d;
    logic [7:0] tctrl_q, tctrl_d, gctrl_q, gctrl_d, period_q, period_d;
    logic [7:0] flags_q, flags_d, mask_q, mask_d;
    logic cnt_wr_q, cnt_wr_d;
    logic [7:0] cnt_wdata_q, cnt_wdata_d;
    logic [2:0] irq_q, irq_d;
    logic [LOCK_CNT_W-1:0] lock_cnt_q, lock_cnt_d;
    logic lock_q, lock_d;
    logic [5:0] idx;
    logic wr_go, wr_lo;
    logic [7:0] wb;
    logic [7:0] duty_rd_a, duty_rd_b;
    logic match_a, match_b;

    // Pin synchronisers
    logic [3:0] fuse_m_q, fuse_s_q;
    logic sysclk_m_q, sysclk_s_q;
    logic legacy_q, legacy_d;

    // Control copies used by the counting logic
    logic [3:0] cs_s_q, cs_s_d;
    logic fast_s_q, fast_s_d, low_s_q, low_s_d;
    logic pwm_a_s_q, pwm_a_s_d, pwm_b_s_q, pwm_b_s_d;
    logic [1:0] mode_a_s_q, mode_a_s_d, mode_b_s_q, mode_b_s_d;
    logic [7:0] period_s_q, period_s_d;

    // Counter
    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic step_q, step_d, ovf_q, ovf_d;
    logic [9:0] pre_q, pre_d, acc_q, acc_d;
    logic [9:0] thr, sum;
    logic [3:0] expo;
    logic tick, use_fast;
    logic [WIDTH-1:0] top;

    assign idx = avs_address[ADDR_W-1:2];
    assign wr_go = avs_write && !wait_q;
    assign wr_lo = wr_go && avs_byteenable[0];
    assign wb = avs_writedata[7:0];

    always_comb begin
        wait_d = 1'b1;
        rdata_d = rdata_q;
        low_speed_d = low_speed_q;
        fce_d = fce_q;
        pll_en_d = pll_en_q;
        tctrl_d = tctrl_q;
        gctrl_d = gctrl_q;
        period_d = period_q;
        mask_d = mask_q;
        flags_d = flags_q;
        cnt_wr_d = 1'b0;
        cnt_wdata_d = cnt_wdata_q;
        if ((avs_read || avs_write) && wait_q) begin
            wait_d = 1'b0;
            rdata_d = '0;
            if (avs_read) begin
                unique case (idx)
                    IDX_PLL_CSR: begin
                        rdata_d[PLL_LOW_SPEED_BIT] = low_speed_q; // (R3)
                        rdata_d[PLL_FAST_EN_BIT] = fce_q;
                        rdata_d[PLL_EN_BIT] = pll_en_q || sysclk_s_q; // (R6)
                        rdata_d[PLL_LOCK_BIT] = lock_q; // (R7)
                    end
                    IDX_TIMER_CTRL: rdata_d[7:0] = tctrl_q & 8'h7F;
                    IDX_GEN_CTRL: rdata_d[7:0] = {legacy_q, gctrl_q[6:0] & 7'h70};
                    IDX_COUNTER: rdata_d[7:0] = cnt_q;
                    IDX_DUTY_A: rdata_d[7:0] = duty_rd_a; // (R14)
                    IDX_DUTY_B: rdata_d[7:0] = duty_rd_b; // (R14)
                    IDX_PERIOD: rdata_d[7:0] = period_q;
                    IDX_FLAGS: rdata_d[7:0] = flags_q;
                    IDX_MASK: rdata_d[7:0] = mask_q;
                    default: rdata_d = '0;
                endcase
            end
        end
        if (wr_lo) begin
            unique case (idx)
                IDX_PLL_CSR: begin
                    low_speed_d = wb[PLL_LOW_SPEED_BIT]; // (R1)
                    pll_en_d = wb[PLL_EN_BIT]; // (R6)
                    fce_d = wb[PLL_FAST_EN_BIT] && pll_en_q; // (R5)
                end
                IDX_TIMER_CTRL: tctrl_d = wb & 8'h7F;
                IDX_GEN_CTRL: gctrl_d = wb & 8'h70;
                IDX_PERIOD: period_d = wb;
                IDX_MASK: mask_d = wb & 8'h64;
                IDX_COUNTER: begin
                    cnt_wr_d = 1'b1;
                    cnt_wdata_d = wb;
                end
                IDX_FLAGS: flags_d = flags_q & ~(wb & 8'h64);
                default: ;
            endcase
        end
        // Flags land one cycle after the event; a set beats a same-cycle clear
        if (ovf_q) begin
            flags_d[FLAG_OVF_BIT] = 1'b1; // (R10) (R21)
        end
        if (match_a) begin
            flags_d[FLAG_CMP_A_BIT] = 1'b1; // (R21)
        end
        if (match_b) begin
            flags_d[FLAG_CMP_B_BIT] = 1'b1;
        end
        irq_d = {flags_q[FLAG_OVF_BIT] && mask_q[FLAG_OVF_BIT],
                 flags_q[FLAG_CMP_A_BIT] && mask_q[FLAG_CMP_A_BIT],
                 flags_q[FLAG_CMP_B_BIT] && mask_q[FLAG_CMP_B_BIT]}
                & {3{global_int_enable}}; // (R16)
        // Lock model: ready a fixed time after enable, lost at once on disable
        lock_cnt_d = lock_cnt_q;
        lock_d = 1'b0;
        if (!pll_en_q) begin
            lock_cnt_d = '0;
        end else if (lock_cnt_q != LOCK_CNT_W'(LOCK_CYCLES)) begin
            lock_cnt_d = lock_cnt_q + 1'b1;
        end else begin
            lock_d = 1'b1; // (R7)
        end
        legacy_d = (fuse_s_q == FUSE_LEGACY); // (R19)
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
            low_speed_q <= 1'b0;
            fce_q <= 1'b0;
            pll_en_q <= 1'b0;
            tctrl_q <= '0;
            gctrl_q <= '0;
            period_q <= PERIOD_RST;
            mask_q <= '0;
            flags_q <= '0;
            cnt_wr_q <= 1'b0;
            cnt_wdata_q <= '0;
            irq_q <= '0;
            lock_cnt_q <= '0;
            lock_q <= 1'b0;
            legacy_q <= 1'b0;
            fuse_m_q <= '0;
            fuse_s_q <= '0;
            sysclk_m_q <= 1'b0;
            sysclk_s_q <= 1'b0;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            low_speed_q <= low_speed_d;
            fce_q <= fce_d;
            pll_en_q <= pll_en_d;
            tctrl_q <= tctrl_d;
            gctrl_q <= gctrl_d;
            period_q <= period_d;
            mask_q <= mask_d;
            flags_q <= flags_d;
            cnt_wr_q <= cnt_wr_d;
            cnt_wdata_q <= cnt_wdata_d;
            irq_q <= irq_d;
            lock_cnt_q <= lock_cnt_d;
            lock_q <= lock_d;
            legacy_q <= legacy_d;
            fuse_m_q <= clock_config_fuses;
            fuse_s_q <= fuse_m_q;
            sysclk_m_q <= pll_is_sysclk;
            sysclk_s_q <= sysclk_m_q;
        end
    end

    // Counting logic sees control one cycle late, as the timer core would
    always_comb begin
        cs_s_d = tctrl_q[3:0];
        fast_s_d = fce_q && !legacy_q; // (R4) (R21)
        low_s_d = low_speed_q;
        pwm_a_s_d = tctrl_q[PWM_EN_BIT]; // (R20)
        pwm_b_s_d = gctrl_q[PWM_EN_BIT];
        mode_a_s_d = tctrl_q[MODE_LSB+1:MODE_LSB];
        mode_b_s_d = gctrl_q[MODE_LSB+1:MODE_LSB];
        period_s_d = period_q;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s_q <= CS_STOP;
            fast_s_q <= 1'b0;
            low_s_q <= 1'b0;
            pwm_a_s_q <= 1'b0;
            pwm_b_s_q <= 1'b0;
            mode_a_s_q <= MODE_OFF;
            mode_b_s_q <= MODE_OFF;
            period_s_q <= PERIOD_RST;
        end else begin
            cs_s_q <= cs_s_d;
            fast_s_q <= fast_s_d;
            low_s_q <= low_s_d;
            pwm_a_s_q <= pwm_a_s_d;
            pwm_b_s_q <= pwm_b_s_d;
            mode_a_s_q <= mode_a_s_d;
            mode_b_s_q <= mode_b_s_d;
            period_s_q <= period_s_d;
        end
    end

    // Fast clock is modelled as a rate accumulator; above 40 MHz it saturates
    // at one count per system clock, so fast /1 at 64 MHz (low-speed clear) runs slower than real silicon.
    always_comb begin
        pre_d = pre_q + 1'b1;
        expo = (cs_s_q <= CS_FAST_DIV8) ? cs_s_q - 4'h1 : cs_s_q - CS_SYS_DIV1;
        use_fast = fast_s_q && cs_s_q != CS_STOP && cs_s_q <= CS_FAST_DIV8; // (R18)
        thr = 10'(CLK_MHZ) << expo[1:0];
        sum = acc_q + (low_s_q ? 10'(FAST_MHZ_LOW) : 10'(FAST_MHZ_HIGH)); // (R1)
        acc_d = '0;
        tick = 1'b0;
        if (cs_s_q == CS_STOP) begin
            tick = 1'b0;
        end else if (use_fast) begin
            acc_d = sum;
            if (sum >= thr) begin
                tick = 1'b1; // (R18)
                acc_d = (sum - thr >= thr) ? thr - 10'h001 : sum - thr;
            end
        end else begin
            tick = (pre_q & div_mask(expo)) == div_mask(expo); // (R4)
        end
        top = (pwm_a_s_q || pwm_b_s_q) ? period_s_q : COUNT_TOP_NORMAL; // (R9)
        cnt_d = cnt_q;
        step_d = 1'b0;
        ovf_d = 1'b0;
        if (cnt_wr_q) begin
            cnt_d = cnt_wdata_q;
        end else if (tick) begin
            step_d = 1'b1;
            if (cnt_q == top) begin
                cnt_d = '0; // (R9) (R17) (R20)
                ovf_d = 1'b1; // (R10)
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q <= '0;
            acc_q <= '0;
            cnt_q <= '0;
            step_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            step_q <= step_d;
            ovf_q <= ovf_d;
        end
    end

    fpt_pwm_chan #(.WIDTH(WIDTH)) u_chan_a (
        .sys_clk(sys_clk), .rst_n(rst_n), .wr_duty(wr_lo && idx == IDX_DUTY_A), .wr_data(wb),
        .pwm_en(pwm_a_s_q), .out_mode(mode_a_s_q), .period(period_s_q), .count(cnt_q),
        .step(step_q), .duty_rd(duty_rd_a), .match(match_a), .out_true(pwm_out_a),
        .out_true_oe(pwm_out_a_oe), .out_comp(pwm_out_a_n), .out_comp_oe(pwm_out_a_n_oe)
    ); // (R12)

    fpt_pwm_chan #(.WIDTH(WIDTH)) u_chan_b (
        .sys_clk(sys_clk), .rst_n(rst_n), .wr_duty(wr_lo && idx == IDX_DUTY_B), .wr_data(wb),
        .pwm_en(pwm_b_s_q), .out_mode(mode_b_s_q), .period(period_s_q), .count(cnt_q),
        .step(step_q), .duty_rd(duty_rd_b), .match(match_b), .out_true(pwm_out_b),
        .out_true_oe(pwm_out_b_oe), .out_comp(pwm_out_b_n), .out_comp_oe(pwm_out_b_n_oe)
    ); // (R12)

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign pll_run = pll_en_q; // (R6)
    assign irq_overflow = irq_q[2];
    assign irq_cmp_a = irq_q[1];
    assign irq_cmp_b = irq_q[0];
endmodule

// [verification/fpt_timer_props.sv]
`timescale 1ns/100ps
module fpt_timer_props
    import fpt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [fpt_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic global_int_enable,
    input wire logic pll_run,
    input wire logic pwm_out_a,
    input wire logic pwm_out_a_oe,
    input wire logic pwm_out_a_n,
    input wire logic pwm_out_a_n_oe,
    input wire logic pwm_out_b,
    input wire logic pwm_out_b_oe,
    input wire logic pwm_out_b_n,
    input wire logic pwm_out_b_n_oe,
    input wire logic irq_overflow,
    input wire logic irq_cmp_a,
    input wire logic irq_cmp_b
);
    localparam int LOCK_MIN = LOCK_CYCLES - 4;
    localparam int LOCK_MAX = LOCK_CYCLES + 8;
    logic rd_pll;
    logic wr_tc;
    logic [12:0] run_cnt_q;
    logic [1:0] mode_a_q;
    assign rd_pll = avs_read && !avs_waitrequest && avs_address[7:2] == IDX_PLL_CSR;
    assign wr_tc = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address[7:2] == IDX_TIMER_CTRL;
    // Saturates so a long-running PLL cannot wrap back under the lock time
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt_q <= 13'h0000;
            mode_a_q <= MODE_OFF;
        end else begin
            run_cnt_q <= !pll_run ? 13'h0000 : run_cnt_q + 13'(run_cnt_q != 13'h1FFF);
            if (wr_tc) begin
                mode_a_q <= avs_writedata[MODE_LSB +: 2];
            end
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one cycle");
    a_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_rsvd_zero: assert property (rd_pll |-> avs_readdata[6:3] == 4'h0)
        else $error("reserved pll bits read nonzero");
    a_lock_early: assert property (rd_pll && avs_readdata[0] |-> run_cnt_q >= LOCK_MIN)
        else $error("lock indicator set too early");
    a_lock_late: assert property (rd_pll && run_cnt_q >= LOCK_MAX |-> avs_readdata[0])
        else $error("lock indicator missing after lock time");
    a_pll_bit: assert property (rd_pll && !avs_readdata[1] |-> !pll_run)
        else $error("pll runs while enable reads zero");
    a_irq_gate: assert property ((irq_overflow || irq_cmp_a || irq_cmp_b) |-> $past(global_int_enable))
        else $error("interrupt raised without global enable");
    a_comp_inv: assert property ((!pwm_out_a_n_oe || (pwm_out_a_n != pwm_out_a && pwm_out_a_oe))
        && (!pwm_out_b_n_oe || (pwm_out_b_n != pwm_out_b && pwm_out_b_oe)))
        else $error("complement output not inverse of true output");
    a_mode_off: assert property ((mode_a_q == MODE_OFF)[*6] |-> !pwm_out_a_oe && !pwm_out_a_n_oe)
        else $error("channel a pins driven in disconnected mode");
    a_no_comp: assert property ((mode_a_q[1])[*6] |-> !pwm_out_a_n_oe)
        else $error("channel a complement driven in single-pin mode");
    c_locked: cover property (rd_pll && avs_readdata[0]);
    c_irq: cover property (irq_overflow && irq_cmp_a);
    c_pair: cover property (pwm_out_a_n_oe && pwm_out_a);
endmodule
bind fpt_timer fpt_timer_props u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .global_int_enable(global_int_enable), .pll_run(pll_run), .pwm_out_a(pwm_out_a),
    .pwm_out_a_oe(pwm_out_a_oe), .pwm_out_a_n(pwm_out_a_n), .pwm_out_a_n_oe(pwm_out_a_n_oe),
    .pwm_out_b(pwm_out_b), .pwm_out_b_n(pwm_out_b_n), .pwm_out_b_n_oe(pwm_out_b_n_oe),
    .pwm_out_b_oe(pwm_out_b_oe), .irq_overflow(irq_overflow), .irq_cmp_a(irq_cmp_a),
    .irq_cmp_b(irq_cmp_b));

// [verification/fpt_load_model.sv]
`timescale 1ns/100ps
// Power stage on the two true pins; an undriven pin is pulled low by the stage
module fpt_load_model (
    input wire logic sys_clk,
    input wire logic clr,
    input wire logic [1:0] pin,
    input wire logic [1:0] pin_oe,
    output logic [1:0] line,
    output int high_cnt [2],
    output int rise_cnt [2]
);
    logic [1:0] line_q;
    assign line = pin_oe & pin;
    always_ff @(posedge sys_clk) begin
        line_q <= line;
        for (int i = 0; i < 2; i++) begin
            high_cnt[i] <= clr ? 0 : high_cnt[i] + int'(line[i]);
            rise_cnt[i] <= clr ? 0 : rise_cnt[i] + int'(line[i] && !line_q[i]);
        end
    end
endmodule

// [verification/testbench.sv]
`timescale 1ns/100ps
module testbench;
    import fpt_pkg::*;
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic global_int_enable = 1'h0;
    logic pll_is_sysclk = 1'h0;
    logic [3:0] clock_config_fuses = 4'h0;
    logic pll_run, irq_overflow, irq_cmp_a, irq_cmp_b;
    logic pwm_out_a, pwm_out_a_oe, pwm_out_a_n, pwm_out_a_n_oe;
    logic pwm_out_b, pwm_out_b_oe, pwm_out_b_n, pwm_out_b_n_oe;
    logic clr = 1'h0;
    logic [1:0] line;
    int high_cnt [2];
    int rise_cnt [2];
    int n_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int c0, n;
    logic [31:0] q;
    logic [7:0] c1, d8;
    logic [3:0] rate_cs [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h2, 4'h3};
    logic rate_ls [6] = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0};
    int rate_exp [6] = '{160, 80, 40, 20, 160, 80};
    logic [1:0] pwm_mode [10] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3};
    logic [7:0] pwm_duty [10] = '{8'h03, 8'h03, 8'h03, 8'h00, 8'h09, 8'h00, 8'h09, 8'h00, 8'h09,
        8'h03};
    int pwm_high [10] = '{0, 2, 2, 0, 10, 0, 10, 10, 0, 8};
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    fpt_timer dut (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .global_int_enable, .pll_is_sysclk,
        .clock_config_fuses, .pll_run, .pwm_out_a, .pwm_out_a_oe, .pwm_out_a_n, .pwm_out_a_n_oe,
        .pwm_out_b, .pwm_out_b_oe, .pwm_out_b_n, .pwm_out_b_n_oe, .irq_overflow, .irq_cmp_a,
        .irq_cmp_b);
    fpt_load_model load (.sys_clk(sys_clk), .clr(clr), .pin({pwm_out_b, pwm_out_a}),
        .pin_oe({pwm_out_b_oe, pwm_out_a_oe}), .line(line), .high_cnt(high_cnt),
        .rise_cnt(rise_cnt));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Starts on an edge and ends one edge after release, so calls may follow directly
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
        int k;
        k = 0;
        avs_address <= {idx, 2'h0};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, d};
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'h0 && k < 20);
        if (k >= 20) chk("bus answer", 32'h0, 32'h1);
        q = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input string what);
        bus(1'h0, idx, 8'h00);
        chk(what, {24'h000000, exp}, q);
    endtask
    task automatic measure(input int ch, input int h, input string what);
        clr <= 1'h1;
        @(posedge sys_clk);
        clr <= 1'h0;
        repeat (41) @(posedge sys_clk);
        chk(what, 4 * h, high_cnt[ch]);
        chk(what, (h % 10 != 0) ? 4 : 0, rise_cnt[ch]);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge sys_clk);
        rd(IDX_PLL_CSR, 8'h00, "pll csr reset");
        rd(IDX_PERIOD, PERIOD_RST, "period reset");
        rd(6'h00, 8'h00, "unmapped read");
        bus(1'h1, IDX_PLL_CSR, 8'h7C);
        rd(IDX_PLL_CSR, 8'h00, "fast enable without pll");
        bus(1'h1, IDX_PLL_CSR, 8'h82);
        chk("pll run", 32'h1, {31'h0, pll_run});
        c0 = cyc;
        q = 32'h0;
        n = 0;
        while (q[0] !== 1'h1 && n < 2000) begin
            bus(1'h0, IDX_PLL_CSR, 8'h00);
            n++;
        end
        chk("lock time", 32'h1, {31'h0, cyc - c0 >= LOCK_CYCLES - 6 && cyc - c0 <= LOCK_CYCLES + 12});
        chk("pll csr locked", 32'h83, q);
        bus(1'h1, IDX_PLL_CSR, 8'h86);
        rd(IDX_PLL_CSR, 8'h87, "fast enable kept");
        for (int i = 0; i < 6; i++) begin
            bus(1'h1, IDX_TIMER_CTRL, 8'h00);
            bus(1'h1, IDX_PLL_CSR, {rate_ls[i], 7'h06});
            bus(1'h1, IDX_TIMER_CTRL, {4'h0, rate_cs[i]});
            bus(1'h0, IDX_COUNTER, 8'h00);
            c1 = q[7:0];
            repeat (197) @(posedge sys_clk);
            bus(1'h0, IDX_COUNTER, 8'h00);
            d8 = q[7:0] - c1;
            chk("count rate", 32'h1, {31'h0, int'(d8) - rate_exp[i] inside {[-2:2]}});
        end
        bus(1'h1, IDX_TIMER_CTRL, 8'h00);
        bus(1'h1, IDX_PLL_CSR, 8'h00);
        bus(1'h1, IDX_COUNTER, 8'h00);
        rd(IDX_COUNTER, 8'h00, "counter load");
        pll_is_sysclk <= 1'h1;
        repeat (3) @(posedge sys_clk);
        rd(IDX_PLL_CSR, 8'h02, "pll enable as system clock");
        pll_is_sysclk <= 1'h0;
        bus(1'h1, IDX_PERIOD, 8'h09);
        for (int i = 0; i < 10; i++) begin
            bus(1'h1, IDX_TIMER_CTRL, {2'h1, pwm_mode[i], CS_SYS_DIV1});
            bus(1'h1, IDX_DUTY_A, pwm_duty[i]);
            rd(IDX_DUTY_A, pwm_duty[i], "duty a readback");
            repeat (25) @(posedge sys_clk);
            measure(0, pwm_high[i], "pwm a");
        end
        bus(1'h1, IDX_GEN_CTRL, 8'h50);
        bus(1'h1, IDX_DUTY_B, 8'h05);
        repeat (25) @(posedge sys_clk);
        measure(1, 4, "pwm b");
        for (int i = 0; i < 8; i++) begin
            bus(1'h0, IDX_COUNTER, 8'h00);
            chk("counter top", 32'h1, {31'h0, q[7:0] <= 8'h09});
        end
        clock_config_fuses <= FUSE_LEGACY;
        repeat (3) @(posedge sys_clk);
        rd(IDX_GEN_CTRL, 8'hD0, "legacy status");
        clock_config_fuses <= 4'h5;
        repeat (3) @(posedge sys_clk);
        rd(IDX_GEN_CTRL, 8'h50, "normal status");
        bus(1'h1, IDX_MASK, 8'h64);
        repeat (12) @(posedge sys_clk);
        chk("irq without global", 32'h0, {29'h0, irq_overflow, irq_cmp_a, irq_cmp_b});
        rd(IDX_FLAGS, 8'h64, "flags set");
        global_int_enable <= 1'h1;
        repeat (3) @(posedge sys_clk);
        chk("irq with global", 32'h7, {29'h0, irq_overflow, irq_cmp_a, irq_cmp_b});
        bus(1'h1, IDX_TIMER_CTRL, 8'h70);
        repeat (5) @(posedge sys_clk);
        bus(1'h1, IDX_FLAGS, 8'h64);
        rd(IDX_FLAGS, 8'h00, "flags cleared");
        repeat (3) @(posedge sys_clk);
        chk("irq after clear", 32'h0, {29'h0, irq_overflow, irq_cmp_a, irq_cmp_b});
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        print_verdict();
    end
endmodule
